// ### hw/afud_pkg.sv
package afud_pkg;

   // ***************************************************************
   // Widths and depths
   // ***************************************************************
   localparam int OCT_W      = 8;
   localparam int CODE_W     = 16;
   localparam int CHAR_W     = 7;
   localparam int WORD_W     = OCT_W + 1;
   localparam int FIFO_DEPTH = 4;

   // ***************************************************************
   // Header and padding octets
   // ***************************************************************
   localparam logic [7:0] HDR_RAW    = 8'h80;
   localparam logic [7:0] HDR_HALF8  = 8'h81;
   localparam logic [7:0] HDR_HALF16 = 8'h82;
   localparam logic [7:0] PAD_OCTET  = 8'hff;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int OFFSET_FLAG_BIT = 7;
   localparam int HALF8_SHIFT     = 7;

   // ***************************************************************
   // Values after reset
   // ***************************************************************
   localparam logic [7:0]  CNT_RST  = 8'h00;
   localparam logic [7:0]  HI_RST   = 8'h00;
   localparam logic [15:0] BASE_RST = 16'h0000;
   localparam logic [15:0] CODE_RST = 16'h0000;

   // ***************************************************************
   // Decoder states
   // ***************************************************************
   typedef enum logic [9:0] {
      S_HDR     = 10'b00_0000_0001,
      S_DEF     = 10'b00_0000_0010,
      S_CNT     = 10'b00_0000_0100,
      S_BASE_HI = 10'b00_0000_1000,
      S_BASE_LO = 10'b00_0001_0000,
      S_CHAR    = 10'b00_0010_0000,
      S_RAW_HI  = 10'b00_0100_0000,
      S_RAW_LO  = 10'b00_1000_0000,
      S_FLUSH   = 10'b01_0000_0000,
      S_END     = 10'b10_0000_0000
   } afud_state_t;

endpackage : afud_pkg

// ### hw/afud_strm_if.sv
`timescale 1ns/1ps
interface afud_strm_if #(
   parameter int W = 9
);
   logic [W-1:0] word;
   logic         valid;
   logic         ready;

   modport src (
      output word,
      output valid,
      input  ready
   );

   modport snk (
      input  word,
      input  valid,
      output ready
   );
endinterface : afud_strm_if

// ### hw/afud_fifo.sv
`timescale 1ns/1ps
module afud_fifo
   import afud_pkg::*;
#(
   parameter int W     = WORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic reset_n_i,
   // Fill side
   afud_strm_if.snk  fill,
   // Drain side
   afud_strm_if.src  drain
);
   localparam int             AW       = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0]    FULL_CNT = DEPTH[AW:0];
   localparam logic [AW-1:0]  LAST_PTR = AW'(DEPTH - 1);

   logic [W-1:0]  mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0]   count_reg;
   logic [AW:0]   count_next;
   logic          not_full_reg;
   logic          not_empty_reg;
   logic          push;
   logic          pop;

   assign push        = fill.valid && not_full_reg;
   assign pop         = not_empty_reg && drain.ready;
   assign fill.ready  = not_full_reg;
   assign drain.valid = not_empty_reg;
   assign drain.word  = mem_reg[rd_ptr_reg];

   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= fill.word;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
         end
      end
   end

   // Flags kept as flops so the ready seen outside is glitch free
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_reg     <= '0;
         not_full_reg  <= 1'b1;
         not_empty_reg <= 1'b0;
      end else begin
         count_reg     <= count_next;
         not_full_reg  <= (count_next != FULL_CNT);
         not_empty_reg <= (count_next != '0);
      end
   end
endmodule : afud_fifo

// ### hw/afud_char_map.sv
`timescale 1ns/1ps
module afud_char_map
   import afud_pkg::*;
(
   // Octet and page base
   input  wire logic [OCT_W-1:0]  octet_i,
   input  wire logic [CODE_W-1:0] base_i,
   input  wire logic              use_base_i,
   // Result
   output logic      [CODE_W-1:0] code_o,
   output logic                   is_default_o
);
   logic [CODE_W-1:0] low7;

   assign low7         = {{(CODE_W-CHAR_W){1'b0}}, octet_i[CHAR_W-1:0]};
   assign is_default_o = !(use_base_i && octet_i[OFFSET_FLAG_BIT]);
   // Sum wraps in 16 bits; a base near the top of code space is the writer's problem
   assign code_o       = is_default_o ? low7 : base_i + low7;
endmodule : afud_char_map

// ### hw/afud_decoder.sv
// Operation
// - One scheme per record; headerless means default alphabet
// - Header 80: octet pairs form upper then lower
// - Header 81: count, then base from third octet
// - 81 data: bit8 clear default, set offset
// - Header 82: count, then two-octet full base
// - 82 data: bit8 clear default, set offset
// - All three schemes always decoded
// - Counted schemes stop at count; FF valid
`timescale 1ns/1ps
module afud_decoder
   import afud_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              reset_n_i,
   // Alpha field octets
   input  wire logic [OCT_W-1:0]  octet_data_i,
   input  wire logic              octet_last_i,
   input  wire logic              octet_valid_i,
   output logic                   octet_ready_o,
   // Code points
   output logic [CODE_W-1:0]      code_o,
   output logic                   code_default_o,
   output logic                   code_valid_o,
   input  wire logic              code_ready_i,
   // Record status
   output logic                   record_done_o
);

   // ***************************************************************
   // Input buffer
   // ***************************************************************
   afud_strm_if #(.W(WORD_W)) in_if ();
   afud_strm_if #(.W(WORD_W)) oct_if ();

   assign in_if.word    = {octet_last_i, octet_data_i};
   assign in_if.valid   = octet_valid_i;
   assign octet_ready_o = in_if.ready;

   afud_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .fill      (in_if),
      .drain     (oct_if)
   );

   // ***************************************************************
   // Declarations
   // ***************************************************************
   afud_state_t       state_reg;
   afud_state_t       state_next;
   logic [OCT_W-1:0]  oct;
   logic              oct_last;
   logic              take_ok;
   logic              acc;
   logic [7:0]        cnt_reg;
   logic [7:0]        hi_reg;
   logic [CODE_W-1:0] base_reg;
   logic              wide_reg;
   logic              emit;
   logic [CODE_W-1:0] emit_code;
   logic              emit_dflt;
   logic [CODE_W-1:0] map_code;
   logic              map_dflt;
   logic [CODE_W-1:0] code_reg;
   logic              dflt_reg;
   logic              valid_reg;
   logic              done_reg;

   assign oct      = oct_if.word[OCT_W-1:0];
   assign oct_last = oct_if.word[OCT_W];
   // Hold the source while the output slot is occupied and not being taken, or done is pending
   assign take_ok  = (state_reg != S_END) && (!valid_reg || code_ready_i);
   assign oct_if.ready = take_ok;
   assign acc      = oct_if.valid && take_ok;

   assign code_o         = code_reg;
   assign code_default_o = dflt_reg;
   assign code_valid_o   = valid_reg;
   assign record_done_o  = done_reg;

   // ***************************************************************
   // Character mapping
   // ***************************************************************
   afud_char_map u_map (
      .octet_i      (oct),
      .base_i       (base_reg),
      .use_base_i   (state_reg == S_CHAR),
      .code_o       (map_code),
      .is_default_o (map_dflt)
   );

   // ***************************************************************
   // Sequencing
   // ***************************************************************
   always_comb begin
      state_next = state_reg;
      emit       = 1'b0;
      emit_code  = map_code;
      emit_dflt  = map_dflt;
      if (acc) begin
         unique case (state_reg)
            S_HDR: begin
               if (oct == HDR_RAW) begin
                  state_next = S_RAW_HI;
               end else if (oct == HDR_HALF8 || oct == HDR_HALF16) begin
                  state_next = S_CNT;
               end else if (oct == PAD_OCTET) begin
                  state_next = S_FLUSH;
               end else begin
                  emit       = 1'b1;
                  state_next = S_DEF;
               end
            end
            S_DEF: begin
               if (oct == PAD_OCTET) begin
                  state_next = S_FLUSH;
               end else begin
                  emit = 1'b1;
               end
            end
            S_CNT: begin
               state_next = S_BASE_HI;
            end
            S_BASE_HI: begin
               if (wide_reg) begin
                  state_next = S_BASE_LO;
               end else begin
                  state_next = (cnt_reg == 8'h00) ? S_FLUSH : S_CHAR;
               end
            end
            S_BASE_LO: begin
               state_next = (cnt_reg == 8'h00) ? S_FLUSH : S_CHAR;
            end
            S_CHAR: begin
               emit       = 1'b1;
               // FF inside the count is an offset, not padding
               state_next = (cnt_reg == 8'h01) ? S_FLUSH : S_CHAR;
            end
            S_RAW_HI: begin
               state_next = (oct == PAD_OCTET) ? S_FLUSH : S_RAW_LO;
            end
            S_RAW_LO: begin
               emit       = 1'b1;
               emit_code  = {hi_reg, oct};
               emit_dflt  = 1'b0;
               state_next = S_RAW_HI;
            end
            S_FLUSH: begin
               state_next = S_FLUSH;
            end
            S_END: begin
               state_next = S_END;
            end
         endcase
         if (oct_last) begin
            state_next = S_END;
         end
      end else if (state_reg == S_END && !valid_reg) begin
         state_next = S_HDR;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= S_HDR;
      end else begin
         state_reg <= state_next;
      end
   end

   // ***************************************************************
   // Header fields
   // ***************************************************************
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_reg  <= CNT_RST;
         hi_reg   <= HI_RST;
         base_reg <= BASE_RST;
         wide_reg <= 1'b0;
      end else if (acc) begin
         unique case (state_reg)
            S_HDR:     wide_reg <= (oct == HDR_HALF16);
            S_CNT:     cnt_reg  <= oct;
            S_BASE_HI: begin
               if (wide_reg) begin
                  base_reg <= {oct, 8'h00};
               end else begin
                  base_reg <= {1'b0, oct, 7'h00};
               end
            end
            S_BASE_LO: base_reg[7:0] <= oct;
            S_CHAR:    cnt_reg  <= cnt_reg - 8'h01;
            S_RAW_HI:  hi_reg   <= oct;
            S_DEF, S_RAW_LO, S_FLUSH, S_END: begin
            end
         endcase
      end
   end

   // ***************************************************************
   // Output beat and done
   // ***************************************************************
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         valid_reg <= 1'b0;
         code_reg  <= CODE_RST;
         dflt_reg  <= 1'b0;
      end else if (emit) begin
         valid_reg <= 1'b1;
         code_reg  <= emit_code;
         dflt_reg  <= emit_dflt;
      end else if (code_ready_i) begin
         valid_reg <= 1'b0;
      end
   end

   // Done only once the last beat has left, so it never overtakes data
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= (state_reg == S_END) && !valid_reg;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   sequence seq_take(afud_state_t st);
      acc && state_reg == st;
   endsequence

   sequence seq_take_mid(afud_state_t st);
      acc && state_reg == st && !oct_last;
   endsequence

   AST_HEADERLESS_DEFAULT: assert property (
      seq_take(S_HDR) ##0 (oct != HDR_RAW && oct != HDR_HALF8 && oct != HDR_HALF16
      && oct != PAD_OCTET) |=> code_valid_o && code_default_o
      && code_o == {9'h000, $past(oct[6:0])})
      else $error("headerless record not decoded as default alphabet");

   // Pair is checked in two steps: upper byte held, then joined with lower
   AST_RAW_UPPER: assert property (
      seq_take(S_RAW_HI) |=> hi_reg == $past(oct))
      else $error("upper byte of raw pair not held");

   AST_RAW_PAIR: assert property (
      seq_take(S_RAW_LO) |=> code_valid_o && !code_default_o
      && code_o == {$past(hi_reg), $past(oct)})
      else $error("raw pair not joined upper then lower");

   AST_RAW_PAD_STOP: assert property (
      seq_take_mid(S_RAW_HI) ##0 oct == PAD_OCTET |=> state_reg == S_FLUSH
      ##0 !code_valid_o || $stable(code_o))
      else $error("raw scheme did not stop on padding");

   AST_BASE_HALF8: assert property (
      seq_take(S_BASE_HI) ##0 !wide_reg |=> base_reg == {1'b0, $past(oct), 7'h00})
      else $error("half page base misplaced");

   AST_OFFSET_CHAR: assert property (
      seq_take(S_CHAR) ##0 oct[7] |=> code_valid_o && !code_default_o
      && code_o == $past(base_reg) + {9'h000, $past(oct[6:0])})
      else $error("offset character not added to base");

   AST_DEFAULT_CHAR: assert property (
      seq_take(S_CHAR) ##0 !oct[7] |=> code_valid_o && code_default_o
      && code_o == {9'h000, $past(oct[6:0])})
      else $error("default character not passed through");

   AST_BASE_HALF16: assert property (
      seq_take(S_BASE_HI) ##0 wide_reg |=> base_reg == {$past(oct), 8'h00})
      else $error("full base upper octet misplaced");

   AST_BASE_FULL_LO: assert property (
      seq_take(S_BASE_LO) |=> base_reg == {$past(base_reg[15:8]), $past(oct)})
      else $error("full base not taken from two octets");

   AST_COUNT_STOP: assert property (
      seq_take_mid(S_CHAR) ##0 cnt_reg == 8'h01 |=> state_reg == S_FLUSH)
      else $error("counted scheme ran past its count");

   AST_FF_IN_COUNT: assert property (
      seq_take_mid(S_CHAR) ##0 (cnt_reg > 8'h01 && oct == PAD_OCTET)
      |=> state_reg == S_CHAR && code_valid_o && !code_default_o)
      else $error("FF inside count treated as padding");

   AST_BEAT_HOLD: assert property (
      code_valid_o && !code_ready_i |=> code_valid_o && $stable(code_o)
      && $stable(code_default_o))
      else $error("code beat dropped before handshake");

   AST_DONE_AFTER_DATA: assert property (
      record_done_o |-> !code_valid_o && $past(state_reg == S_END) && state_reg == S_HDR
      ##1 !record_done_o)
      else $error("done not a single pulse after last beat");

   AST_LAST_ENDS: assert property (
      acc && oct_last |=> state_reg == S_END && !oct_if.ready)
      else $error("record end not honoured");

endmodule : afud_decoder

// ### bench/afud_card_src.sv
`timescale 1ns/1ps
module afud_card_src
   import afud_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             reset_n_i,
   // Octets toward the decoder
   output logic      [OCT_W-1:0] octet_data_o,
   output logic                  octet_last_o,
   output logic                  octet_valid_o,
   input  wire logic             octet_ready_i
);
   int gap = 0;

   initial begin
      octet_data_o  = 8'h00;
      octet_last_o  = 1'b0;
      octet_valid_o = 1'b0;
   end

   // ***************************************************************
   // Record sender
   // ***************************************************************
   // Octet held until taken; released line shows the inverse, not stale data
   task automatic send(input logic [7:0] rec[$]);
      int i;
      int w;
      for (i = 0; i < rec.size(); i++) begin
         octet_data_o  <= rec[i];
         octet_last_o  <= (i == rec.size() - 1);
         octet_valid_o <= 1'b1;
         for (w = 0; w < 1000; w++) begin
            @(posedge clk_sys_i);
            if (octet_ready_i === 1'b1) break;
         end
         if (gap > 0) begin
            octet_valid_o <= 1'b0;
            octet_data_o  <= ~rec[i];
            repeat (gap) @(posedge clk_sys_i);
         end
      end
      octet_valid_o <= 1'b0;
      octet_last_o  <= 1'b0;
      octet_data_o  <= ~rec[rec.size() - 1];
   endtask : send
endmodule : afud_card_src

// ### bench/alpha_field_ucs2_decoder_test.sv
`timescale 1ns/1ps
module alpha_field_ucs2_decoder_test
   import afud_pkg::*;
;
   logic              clk_sys_i = 1'b0;
   logic              reset_n_i = 1'b0;
   logic [OCT_W-1:0]  octet_data;
   logic              octet_last;
   logic              octet_valid;
   logic              octet_ready_o;
   logic [CODE_W-1:0] code_o;
   logic              code_default_o;
   logic              code_valid_o;
   logic              code_ready_i = 1'b0;
   logic              record_done_o;
   int                n_errors = 0;
   int                checks_done = 0;

   always #20 clk_sys_i = ~clk_sys_i;

   afud_decoder dut_u (
      .clk_sys_i      (clk_sys_i),
      .reset_n_i      (reset_n_i),
      .octet_data_i   (octet_data),
      .octet_last_i   (octet_last),
      .octet_valid_i  (octet_valid),
      .octet_ready_o  (octet_ready_o),
      .code_o         (code_o),
      .code_default_o (code_default_o),
      .code_valid_o   (code_valid_o),
      .code_ready_i   (code_ready_i),
      .record_done_o  (record_done_o)
   );

   afud_card_src src_u (
      .clk_sys_i     (clk_sys_i),
      .reset_n_i     (reset_n_i),
      .octet_data_o  (octet_data),
      .octet_last_o  (octet_last),
      .octet_valid_o (octet_valid),
      .octet_ready_i (octet_ready_o)
   );

   // ***************************************************************
   // Checking and reporting
   // ***************************************************************
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // Value is {default flag, code point}
   task automatic check_val(input logic [16:0] got, input logic [16:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   // Beats compared in order; count checked when the record closes
   task automatic collect(input logic [16:0] exp[$], input bit stall);
      int n;
      int k;
      n = 0;
      for (k = 0; k < 500; k++) begin
         @(posedge clk_sys_i);
         if (code_valid_o === 1'b1 && code_ready_i === 1'b1) begin
            check_val({code_default_o, code_o},
                      (n < exp.size()) ? exp[n] : 17'h1ffff);
            n++;
         end
         if (record_done_o === 1'b1) begin
            check_val(17'(n), 17'(exp.size()));
            check_val({16'h0000, code_valid_o}, 17'h00000);
            break;
         end
         code_ready_i <= stall ? ~code_ready_i : 1'b1;
      end
      if (k == 500) begin
         n_errors++;
         summarize();
      end else begin
         code_ready_i <= 1'b0;
      end
   endtask : collect

   task automatic run(input logic [7:0] rec[$], input logic [16:0] exp[$],
                      input bit stall);
      fork
         src_u.send(rec);
         collect(exp, stall);
      join
   endtask : run

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   // Upper byte first; FF in lower byte is data, FF in upper byte pads
   task automatic sc_raw();
      run('{8'h80, 8'h01, 8'h41, 8'h04, 8'hff, 8'hff, 8'hff},
          '{17'h00141, 17'h004ff}, 1'b0);
   endtask : sc_raw

   // Half page from one octet; FF inside count is an offset
   task automatic sc_half8();
      src_u.gap = 2;
      run('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'ha6, 8'h41, 8'hff, 8'h33},
          '{17'h10053, 17'h00995, 17'h009a6, 17'h10041, 17'h009ff},
          1'b0);
      src_u.gap = 0;
   endtask : sc_half8

   // Full base pointer, consumer stalling
   task automatic sc_half16();
      run('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2d,
            8'h82, 8'hd3, 8'h2d, 8'h31, 8'h85},
          '{17'h1002d, 17'h00532, 17'h00583, 17'h1002d, 17'h10031},
          1'b1);
   endtask : sc_half16

   // Headerless record, bit 7 ignored, stops at first FF
   task automatic sc_plain();
      run('{8'h48, 8'h69, 8'hc1, 8'hff, 8'h55},
          '{17'h10048, 17'h10069, 17'h10041}, 1'b0);
   endtask : sc_plain

   // Empty, zero count, FF early in count and record ending before its count
   task automatic sc_edges();
      logic [16:0] none[$];
      none = {};
      run('{8'hff}, none, 1'b0);
      run('{8'h81, 8'h00, 8'h13, 8'h41}, none, 1'b0);
      run('{8'h81, 8'h02, 8'h13, 8'hff, 8'h41}, '{17'h009ff, 17'h10041}, 1'b0);
      run('{8'h82, 8'h03, 8'h05, 8'h30, 8'h2d}, '{17'h1002d}, 1'b1);
   endtask : sc_edges

   initial begin
      repeat (2) @(posedge clk_sys_i);
      check_val({15'h0000, octet_ready_o, code_valid_o}, 17'h00002);
      check_val({16'h0000, record_done_o}, 17'h00000);
      reset_n_i <= 1'b1;
      @(posedge clk_sys_i);
      sc_raw();
      sc_half8();
      sc_half16();
      sc_plain();
      sc_edges();
      sc_raw();
      summarize();
   end
endmodule : alpha_field_ucs2_decoder_test
